// *** rtl/gom_pin_mux.sv ***
// per-pin output source and signal selector
`timescale 1ns/100ps
`default_nettype none
module gom_pin_mux (
  // control byte of this pin
  input  wire logic [7:0]  i_ctl,
  // status from the hub
  gom_status_if.consumer   st,
  // selected level and driver enable
  output logic             o_level,
  output logic             o_drive
);
  logic [2:0] src;
  logic [2:0] sel;
  logic [1:0] rx_idx;
  logic       tx_idx;

  assign src    = i_ctl[gom_pkg::SRC_MSB:gom_pkg::SRC_LSB];
  assign sel    = i_ctl[gom_pkg::SEL_MSB:gom_pkg::SEL_LSB];
  assign rx_idx = src[1:0];
  assign tx_idx = src[0];
  assign o_drive = i_ctl[gom_pkg::EN_BIT];

  always_comb
  begin
    o_level = 1'b0;
    if (src <= gom_pkg::SRC_RX3)
    begin
      case (sel)
        gom_pkg::RX_LOCK: o_level = st.rx_lock[rx_idx];
        gom_pkg::RX_PASS: o_level = st.rx_pass[rx_idx];
        gom_pkg::RX_FV:   o_level = st.rx_fv[rx_idx];
        gom_pkg::RX_LV:   o_level = st.rx_lv[rx_idx];
        default:          o_level = st.rx_gpio[rx_idx][sel[1:0]];
      endcase
    end
    else if (src == gom_pkg::SRC_DEV)
    begin
      case (sel)
        gom_pkg::DEV_VAL:      o_level = i_ctl[gom_pkg::VAL_BIT];
        gom_pkg::DEV_LOCK_OR:  o_level = st.lock_or;
        gom_pkg::DEV_LOCK_AND: o_level = st.lock_and;
        gom_pkg::DEV_PASS_AND: o_level = st.pass_and;
        gom_pkg::DEV_CAM_SYNC: o_level = st.cam_sync;
        default:               o_level = 1'b0;
      endcase
    end
    else if (src == gom_pkg::SRC_TX0 || src == gom_pkg::SRC_TX1)
    begin
      case (sel)
        gom_pkg::TX_PASS_AND: o_level = st.tx_pass_and[tx_idx];
        gom_pkg::TX_PASS_OR:  o_level = st.tx_pass_or[tx_idx];
        gom_pkg::TX_FV:       o_level = st.tx_fv[tx_idx];
        gom_pkg::TX_LV:       o_level = st.tx_lv[tx_idx];
        gom_pkg::TX_SYNCED:   o_level = st.tx_synced[tx_idx];
        gom_pkg::TX_IRQ:      o_level = st.tx_irq[tx_idx];
        default:              o_level = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/gom_pkg.sv ***
// constants for the two-pin output source multiplexer
// Overview of operation
// - source field picks rx port 0-3, device status, or tx port 0/1; 101 reserved
// - rx source: select 000-011 outputs that port's remote gpio 0-3
// - rx source: select 100 outputs lock, 101 outputs pass of that port
// - rx source: select 110 outputs frame valid, 111 line valid
// - device status: select 000 outputs the pin's own held value bit
// - device status: select 001 outputs OR of lock over enabled rx ports
// - device status: 010 AND of lock, 011 AND of pass over enabled ports
// - device status: 100 outputs camera sync signal; 101-111 reserved
// - tx source: 000 AND, 001 OR of pass over rx ports assigned to it
// - tx source: 010 frame being sent, 011 line being sent
// - tx source: 100 multi-port synchronized, 101 port interrupt; 110-111 reserved
// - held value bit 1 gives the level when register value is selected
// - enable bit 0 turns driver off at 0, on at 1; all fields reset 0
// - pin 1 and pin 2 control registers at 0x11 and 0x12, read-write
// - registers reached through the serial control bus register map
package gom_pkg;
  localparam logic [7:0] PIN1_CTL_ADDR = 8'h11;
  localparam logic [7:0] PIN2_CTL_ADDR = 8'h12;
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int SRC_MSB = 4;
  localparam int SRC_LSB = 2;
  localparam int VAL_BIT = 1;
  localparam int EN_BIT  = 0;
  localparam int NUM_RX  = 4;
  localparam int NUM_TX  = 2;
  localparam int SYNC_W  = 32;
  localparam logic [2:0] SRC_RX0 = 3'h0;
  localparam logic [2:0] SRC_RX3 = 3'h3;
  localparam logic [2:0] SRC_DEV = 3'h4;
  localparam logic [2:0] SRC_TX0 = 3'h6;
  localparam logic [2:0] SRC_TX1 = 3'h7;
  localparam logic [2:0] RX_LOCK = 3'h4;
  localparam logic [2:0] RX_PASS = 3'h5;
  localparam logic [2:0] RX_FV   = 3'h6;
  localparam logic [2:0] RX_LV   = 3'h7;
  localparam logic [2:0] DEV_VAL      = 3'h0;
  localparam logic [2:0] DEV_LOCK_OR  = 3'h1;
  localparam logic [2:0] DEV_LOCK_AND = 3'h2;
  localparam logic [2:0] DEV_PASS_AND = 3'h3;
  localparam logic [2:0] DEV_CAM_SYNC = 3'h4;
  localparam logic [2:0] TX_PASS_AND = 3'h0;
  localparam logic [2:0] TX_PASS_OR  = 3'h1;
  localparam logic [2:0] TX_FV       = 3'h2;
  localparam logic [2:0] TX_LV       = 3'h3;
  localparam logic [2:0] TX_SYNCED   = 3'h4;
  localparam logic [2:0] TX_IRQ      = 3'h5;
endpackage

// *** rtl/gom_status_if.sv ***
// status bundle shared by the register block and the per-pin selectors
`timescale 1ns/100ps
`default_nettype none
interface gom_status_if;
  logic [3:0][3:0] rx_gpio;
  logic [3:0]      rx_lock;
  logic [3:0]      rx_pass;
  logic [3:0]      rx_fv;
  logic [3:0]      rx_lv;
  logic            lock_or;
  logic            lock_and;
  logic            pass_and;
  logic            cam_sync;
  logic [1:0]      tx_pass_and;
  logic [1:0]      tx_pass_or;
  logic [1:0]      tx_fv;
  logic [1:0]      tx_lv;
  logic [1:0]      tx_synced;
  logic [1:0]      tx_irq;
  modport producer (
    output rx_gpio, rx_lock, rx_pass, rx_fv, rx_lv, lock_or, lock_and,
    output pass_and, cam_sync, tx_pass_and, tx_pass_or, tx_fv, tx_lv,
    output tx_synced, tx_irq
  );
  modport consumer (
    input rx_gpio, rx_lock, rx_pass, rx_fv, rx_lv, lock_or, lock_and,
    input pass_and, cam_sync, tx_pass_and, tx_pass_or, tx_fv, tx_lv,
    input tx_synced, tx_irq
  );
endinterface
`default_nettype wire

// *** rtl/gom_top.sv ***
// two-pin output source multiplexer with its control registers
`timescale 1ns/100ps
`default_nettype none
module gom_top (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // register map access from the serial control bus
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic             o_reg_ack,
  // receive port status, from the link clock domains
  input  wire logic [15:0] i_rx_gpio,
  input  wire logic [3:0]  i_rx_lock,
  input  wire logic [3:0]  i_rx_pass,
  input  wire logic [3:0]  i_rx_fv,
  input  wire logic [3:0]  i_rx_lv,
  // core clock status
  input  wire logic [3:0]  i_rx_port_en,
  input  wire logic [3:0]  i_tx0_rx_map,
  input  wire logic [3:0]  i_tx1_rx_map,
  input  wire logic        i_camera_sync_signal,
  input  wire logic [1:0]  i_tx_frame,
  input  wire logic [1:0]  i_tx_line,
  input  wire logic [1:0]  i_tx_synced,
  input  wire logic [1:0]  i_tx_irq,
  // pin drivers
  output logic             o_pin1_out,
  output logic             o_pin1_oe,
  output logic             o_pin2_out,
  output logic             o_pin2_oe
);
  logic [7:0] pin1_output_control_q;
  logic [7:0] pin2_output_control_q;
  logic [gom_pkg::SYNC_W-1:0] meta_q;
  logic [gom_pkg::SYNC_W-1:0] sync_q;
  logic [gom_pkg::SYNC_W-1:0] raw_in;
  logic [15:0] gpio_s;
  logic [3:0]  lock_s;
  logic [3:0]  pass_s;
  logic [3:0]  fv_s;
  logic [3:0]  lv_s;
  logic [3:0]  lock_en;
  logic [3:0]  pass_en;
  logic        any_en;
  logic [3:0]  tx0_pass_and;
  logic [3:0]  tx1_pass_and;
  logic        pin1_level;
  logic        pin1_drive;
  logic        pin2_level;
  logic        pin2_drive;
  logic        hit1;
  logic        hit2;
  logic [7:0]  rdata_d;

  gom_status_if u_status ();

  // link-side signals pass two flops before any use
  assign raw_in = {i_rx_lv, i_rx_fv, i_rx_pass, i_rx_lock, i_rx_gpio};

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  assign gpio_s = sync_q[15:0];
  assign lock_s = sync_q[19:16];
  assign pass_s = sync_q[23:20];
  assign fv_s   = sync_q[27:24];
  assign lv_s   = sync_q[31:28];

  // disabled ports count as lock or pass for the and terms only
  assign lock_en = lock_s | ~i_rx_port_en;
  assign pass_en = pass_s | ~i_rx_port_en;
  // with no port enabled the and terms read low, not vacuously high
  assign any_en  = |i_rx_port_en;
  assign tx0_pass_and = pass_s | ~i_tx0_rx_map;
  assign tx1_pass_and = pass_s | ~i_tx1_rx_map;

  assign u_status.rx_gpio = gpio_s;
  assign u_status.rx_lock = lock_s;
  assign u_status.rx_pass = pass_s;
  assign u_status.rx_fv   = fv_s;
  assign u_status.rx_lv   = lv_s;
  assign u_status.lock_or  = |(lock_s & i_rx_port_en);
  assign u_status.lock_and = any_en & (&lock_en);
  assign u_status.pass_and = any_en & (&pass_en);
  assign u_status.cam_sync = i_camera_sync_signal;
  assign u_status.tx_pass_and[0] = (|i_tx0_rx_map) & (&tx0_pass_and);
  assign u_status.tx_pass_and[1] = (|i_tx1_rx_map) & (&tx1_pass_and);
  assign u_status.tx_pass_or[0]  = |(pass_s & i_tx0_rx_map);
  assign u_status.tx_pass_or[1]  = |(pass_s & i_tx1_rx_map);
  assign u_status.tx_fv     = i_tx_frame;
  assign u_status.tx_lv     = i_tx_line;
  assign u_status.tx_synced = i_tx_synced;
  assign u_status.tx_irq    = i_tx_irq;

  // register decode
  assign hit1 = (i_reg_addr == gom_pkg::PIN1_CTL_ADDR);
  assign hit2 = (i_reg_addr == gom_pkg::PIN2_CTL_ADDR);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      pin1_output_control_q <= gom_pkg::CTL_RESET;
    end
    else if (i_reg_wr && hit1)
    begin
      pin1_output_control_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      pin2_output_control_q <= gom_pkg::CTL_RESET;
    end
    else if (i_reg_wr && hit2)
    begin
      pin2_output_control_q <= i_reg_wdata;
    end
  end

  // unmapped addresses read as zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (hit1)
    begin
      rdata_d = pin1_output_control_q;
    end
    else if (hit2)
    begin
      rdata_d = pin2_output_control_q;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 8'h00;
    end
    else if (i_reg_rd)
    begin
      o_reg_rdata <= rdata_d;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_reg_ack <= 1'b0;
    end
    else
    begin
      o_reg_ack <= i_reg_wr | i_reg_rd;
    end
  end

  gom_pin_mux u_pin1 (
    .i_ctl   (pin1_output_control_q),
    .st      (u_status.consumer),
    .o_level (pin1_level),
    .o_drive (pin1_drive)
  );

  gom_pin_mux u_pin2 (
    .i_ctl   (pin2_output_control_q),
    .st      (u_status.consumer),
    .o_level (pin2_level),
    .o_drive (pin2_drive)
  );

  // registered pins avoid glitches while the select changes
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_pin1_out <= 1'b0;
      o_pin1_oe  <= 1'b0;
    end
    else
    begin
      o_pin1_out <= pin1_level;
      o_pin1_oe  <= pin1_drive;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_pin2_out <= 1'b0;
      o_pin2_oe  <= 1'b0;
    end
    else
    begin
      o_pin2_out <= pin2_level;
      o_pin2_oe  <= pin2_drive;
    end
  end
endmodule
`default_nettype wire

// *** tb/gom_pin_sampler.sv ***
// board-side sampler of one pin
`timescale 1ns/100ps
`default_nettype none
module gom_pin_sampler (
  // clock and pin
  input  wire logic i_ref_clk,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  // level seen on the board
  output logic      o_seen
);
  // pull-up holds the line while the driver is off
  always_ff @(posedge i_ref_clk)
  begin
    o_seen <= i_pin_oe ? i_pin_out : 1'b1;
  end
endmodule
`default_nettype wire

// *** tb/gom_top_chk.sv ***
// port checker for the two-pin output multiplexer
`timescale 1ns/100ps
`default_nettype none
module gom_top_chk (
  // clock, reset, register port
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_ack,
  // pins
  input wire logic       o_pin1_out,
  input wire logic       o_pin1_oe,
  input wire logic       o_pin2_out,
  input wire logic       o_pin2_oe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_wr1;
    i_reg_wr && i_reg_addr == 8'h11;
  endsequence
  sequence s_wr2;
    i_reg_wr && i_reg_addr == 8'h12;
  endsequence
  a_ack_after_req: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
    else $error("ack missing");
  a_ack_needs_req: assert property (o_reg_ack |-> $past(i_reg_wr || i_reg_rd))
    else $error("ack without request");
  a_pin1_enable: assert property (s_wr1 |-> ##2 o_pin1_oe == $past(i_reg_wdata[0], 2))
    else $error("pin1 enable wrong");
  a_pin2_enable: assert property (s_wr2 |-> ##2 o_pin2_oe == $past(i_reg_wdata[0], 2))
    else $error("pin2 enable wrong");
  a_rsv_src_low: assert property (s_wr1 ##0 i_reg_wdata[4:2] == 3'h5 |-> ##2 !o_pin1_out)
    else $error("reserved source not low");
  a_held_value: assert property (s_wr2 ##0 i_reg_wdata[7:2] == 6'h04
    |-> ##2 o_pin2_out == $past(i_reg_wdata[1], 2))
    else $error("held value wrong");
  a_bad_addr_zero: assert property (i_reg_rd && !(i_reg_addr inside {8'h11, 8'h12})
    |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // reset itself is the antecedent, so the default disable is overridden
  a_reset_clears: assert property (disable iff (1'b0) i_reset
    |=> !o_pin1_oe && !o_pin2_oe && o_reg_rdata == 8'h00)
    else $error("reset left outputs set");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
endmodule
bind gom_top gom_top_chk i_chk (.i_ref_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_pin1_out, .o_pin1_oe, .o_pin2_out, .o_pin2_oe);
`default_nettype wire

// *** tb/gom_top_tb.sv ***
// self-checking bench for the two-pin output multiplexer
`timescale 1ns/100ps
`default_nettype none
module gom_top_tb;
  logic        clk, rst, wr, rd, ack, p1o, p1e, p2o, p2e, cs, s1, s2;
  logic [7:0]  addr, wd, rdata;
  logic [15:0] gpio;
  logic [3:0]  lock, pass, fv, lv, en, m0, m1;
  logic [1:0]  tf, tl, ts, ti;
  int          err_total, comparisons;

  gom_top i_dut (.i_ref_clk(clk), .i_reset(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_rx_gpio(gpio), .i_rx_lock(lock), .i_rx_pass(pass), .i_rx_fv(fv), .i_rx_lv(lv),
    .i_rx_port_en(en), .i_tx0_rx_map(m0), .i_tx1_rx_map(m1), .i_camera_sync_signal(cs),
    .i_tx_frame(tf), .i_tx_line(tl), .i_tx_synced(ts), .i_tx_irq(ti),
    .o_pin1_out(p1o), .o_pin1_oe(p1e), .o_pin2_out(p2o), .o_pin2_oe(p2e));
  gom_pin_sampler i_b1 (.i_ref_clk(clk), .i_pin_out(p1o), .i_pin_oe(p1e), .o_seen(s1));
  gom_pin_sampler i_b2 (.i_ref_clk(clk), .i_pin_out(p2o), .i_pin_oe(p2e), .o_seen(s2));

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
    chk("ack", {7'h00, ack}, 8'h01);
  endtask

  task automatic rreg(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk);
    rd = 0;
    chk("rdata", rdata, e);
  endtask

  function automatic logic [7:0] cw(logic [2:0] s, logic [2:0] r);
    return {s, r, 2'h1};
  endfunction

  // each pin gets the byte in turn, the other one idle, so a swapped pin shows
  // a disabled driver must read as the pull-up
  task automatic pin(logic [7:0] c, logic e);
    for (int k = 0; k < 2; k++)
    begin
      wreg(8'h11, k ? 8'h00 : c);
      wreg(8'h12, k ? c : 8'h00);
      repeat (4) @(negedge clk);
      chk("pin1", {7'h00, s1}, {7'h00, (c[0] && k == 0) ? e : 1'b1});
      chk("pin2", {7'h00, s2}, {7'h00, (c[0] && k == 1) ? e : 1'b1});
    end
  endtask

  // reset in mid-run must clear both control bytes and the drivers
  task automatic t_rst();
    wreg(8'h11, 8'hFF);
    wreg(8'h12, 8'hFF);
    @(negedge clk);
    rst = 1;
    repeat (3) @(negedge clk);
    rst = 0;
    chk("pin1 oe", {7'h00, p1e}, 8'h00);
    chk("pin2 oe", {7'h00, p2e}, 8'h00);
    rreg(8'h11, 8'h00);
    rreg(8'h12, 8'h00);
  endtask

  task automatic t_regs();
    rreg(8'h11, 8'h00);
    rreg(8'h12, 8'h00);
    wreg(8'h11, 8'hA5);
    wreg(8'h12, 8'h5A);
    wreg(8'h10, 8'hFF);
    rreg(8'h11, 8'hA5);
    rreg(8'h12, 8'h5A);
    rreg(8'h10, 8'h00);
  endtask

  // every other rx input holds the opposite level, so a wrong pick shows
  task automatic t_rx();
    for (int p = 0; p < 4; p++)
      for (int s = 0; s < 8; s++)
        for (int v = 0; v < 2; v++)
        begin
          gpio = {16{~v[0]}};
          {lock, pass, fv, lv} = {16{~v[0]}};
          if (s < 4)
            gpio[4 * p + s] = v[0];
          if (s == 4)
            lock[p] = v[0];
          if (s == 5)
            pass[p] = v[0];
          if (s == 6)
            fv[p] = v[0];
          if (s == 7)
            lv[p] = v[0];
          pin(cw(s[2:0], p[2:0]), v[0]);
        end
  endtask

  task automatic t_dev();
    en = 4'h5;
    lock = 4'h4;
    pass = 4'h5;
    cs = 1'b1;
    pin(8'h13, 1'b1);
    pin(8'h11, 1'b0);
    pin(8'h10, 1'b0);
    pin(8'h31, 1'b1);
    pin(8'h51, 1'b0);
    pin(8'h71, 1'b1);
    pin(8'h91, 1'b1);
    pin(8'hB1, 1'b0);
    pin(8'hF3, 1'b0);
    pin(8'h17, 1'b0);
    lock = 4'hD;
    pass = 4'h4;
    cs = 1'b0;
    pin(8'h51, 1'b1);
    pin(8'h71, 1'b0);
    pin(8'h91, 1'b0);
    lock = 4'hA;
    pin(8'h31, 1'b0);
    // no port enabled: and terms must not read vacuously high
    en = 4'h0;
    lock = 4'hF;
    pass = 4'hF;
    pin(8'h31, 1'b0);
    pin(8'h51, 1'b0);
    pin(8'h71, 1'b0);
  endtask

  task automatic t_tx();
    logic [3:0] mp;
    logic [2:0] r;
    m0 = 4'h3;
    m1 = 4'hC;
    {tf, tl, ts, ti} = 8'h96;
    for (int t = 0; t < 2; t++)
    begin
      mp = t ? m1 : m0;
      r = 3'h6 + t[2:0];
      for (int k = 0; k < 2; k++)
      begin
        pass = k ? 4'hD : 4'h1;
        pin(cw(3'h0, r), &(pass | ~mp));
        pin(cw(3'h1, r), |(pass & mp));
      end
      pin(cw(3'h2, r), tf[t]);
      pin(cw(3'h3, r), tl[t]);
      pin(cw(3'h4, r), ts[t]);
      pin(cw(3'h5, r), ti[t]);
      pin(cw(3'h6, r), 1'b0);
      pin(cw(3'h7, r), 1'b0);
    end
  endtask

  initial
  begin
    {wr, rd, cs, addr, wd, gpio} = '0;
    {lock, pass, fv, lv, m0, m1, tf, tl, ts, ti} = '0;
    en = 4'hF;
    rst = 1;
    repeat (12) @(negedge clk);
    rst = 0;
    t_regs();
    t_rst();
    t_rx();
    t_dev();
    t_tx();
    give_verdict();
  end

  // hang guard far beyond the full run of about 1660 cycles
  initial
  begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
